// ===== hdl/svvd_map.vh
`ifndef SVVD_MAP_VH
`define SVVD_MAP_VH
`define SVVD_OFS_VPP        8'h10
`define SVVD_OFS_VIDEO      8'h20
`define SVVD_OFS_DMA        8'h24
`define SVVD_OFS_LEGACY_3A  8'h28
`define SVVD_OFS_SENSE      8'h2c
`define SVVD_LEGACY_VID_BIT 3
`define SVVD_VPP_0V         3'h0
`define SVVD_VPP_12V        3'h1
`define SVVD_VPP_5V         3'h2
`define SVVD_VPP_3V3        3'h3
`define SVVD_RESET_VPP      3'h0
`define SVVD_RESET_DMA      3'h0
`define SVVD_RESET_LEGACY   8'h00
`endif

// ===== hdl/svvd_regs.v
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "svvd_map.vh"
module svvd_regs (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        card_detect_n,
    input  wire [1:0]  voltage_sense,
    output reg  [2:0]  vpp_request,
    output reg         video_passthrough_en,
    output reg  [2:0]  socket_dma_channel_number,
    output reg  [3:0]  allowed_voltages
);
    // The address phase is captured so that a write can land when its
    // data arrives in the following cycle.
    reg         wr_pend_reg;
    reg         wr_pend_next;
    reg [7:0]   wr_addr_reg;
    reg [7:0]   wr_addr_next;
    reg [31:0]  hrdata_next;
    reg [2:0]   vpp_next;
    reg         video_next;
    reg [2:0]   dma_next;
    reg [7:0]   legacy_3a_reg;
    reg [7:0]   legacy_3a_next;
    reg [3:0]   allowed_next;
    wire        take;
    wire        take_rd;
    wire        take_wr;
    wire        wr_vpp;
    wire        wr_video;
    wire        wr_dma;
    wire        wr_legacy;
    wire [31:0] rd_word;

    function svvd_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            svvd_hit = (addr == offset);
        end
    endfunction

    // Bit 3 of the legacy byte reads back from the passthrough bit, not from
    // legacy_3a_reg, so both views always agree; its stored bit 3 is never read.
    function [31:0] svvd_read_word;
        input [7:0] addr;
        input [2:0] vpp;
        input       video;
        input [2:0] dma;
        input [7:0] legacy;
        input [3:0] allowed;
        begin
            case (addr)
                `SVVD_OFS_VPP: begin
                    svvd_read_word = {29'h0, vpp};
                end
                `SVVD_OFS_VIDEO: begin
                    svvd_read_word = {31'h0, video};
                end
                `SVVD_OFS_DMA: begin
                    svvd_read_word = {29'h0, dma};
                end
                `SVVD_OFS_LEGACY_3A: begin
                    svvd_read_word = {24'h0,
                                      legacy[7:4],
                                      video,
                                      legacy[2:0]};
                end
                `SVVD_OFS_SENSE: begin
                    svvd_read_word = {28'h0, allowed};
                end
                default: begin
                    svvd_read_word = 32'h0;
                end
            endcase
        end
    endfunction

    // Simple card detect and voltage sense decode; bits are
    // {reserved, 3.3V, 5.0V, 12.0V}. No card means nothing allowed.
    function [3:0] svvd_allowed;
        input       detect_n;
        input [1:0] sense;
        begin
            svvd_allowed = 4'h0;
            if (!detect_n) begin
                case (sense)
                    2'b00: begin
                        svvd_allowed = 4'h7;
                    end
                    2'b01: begin
                        svvd_allowed = 4'h5;
                    end
                    2'b10: begin
                        svvd_allowed = 4'h3;
                    end
                    default: begin
                        svvd_allowed = 4'h4;
                    end
                endcase
            end
        end
    endfunction

    assign take      = hsel && hready && htrans[1];
    assign take_rd   = take && !hwrite;
    assign take_wr   = take && hwrite;
    assign wr_vpp    = wr_pend_reg && svvd_hit(wr_addr_reg, `SVVD_OFS_VPP);
    assign wr_video  = wr_pend_reg && svvd_hit(wr_addr_reg, `SVVD_OFS_VIDEO);
    assign wr_dma    = wr_pend_reg && svvd_hit(wr_addr_reg, `SVVD_OFS_DMA);
    assign wr_legacy = wr_pend_reg &&
                       svvd_hit(wr_addr_reg, `SVVD_OFS_LEGACY_3A);
    assign rd_word   = svvd_read_word(haddr,
                                      vpp_request,
                                      video_passthrough_en,
                                      socket_dma_channel_number,
                                      legacy_3a_reg,
                                      allowed_voltages);

    always @* begin
        wr_pend_next = take_wr;
        wr_addr_next = wr_addr_reg;
        if (take) begin
            wr_addr_next = haddr;
        end
    end

    // Read data is registered, so it stands through the data phase and
    // holds until the next read.
    always @* begin
        hrdata_next = hrdata;
        if (take_rd) begin
            hrdata_next = rd_word;
        end
    end

    // Reserved codes are stored as written; the power logic must treat
    // them as unsafe.
    always @* begin
        vpp_next = vpp_request;
        if (wr_vpp) begin
            vpp_next = hwdata[2:0];
        end
    end

    always @* begin
        video_next = video_passthrough_en;
        if (wr_video) begin
            video_next = hwdata[0];
        end else if (wr_legacy) begin
            video_next = hwdata[`SVVD_LEGACY_VID_BIT];
        end
    end

    // Only the low three bits are kept; upper bits are dropped.
    always @* begin
        dma_next = socket_dma_channel_number;
        if (wr_dma) begin
            dma_next = hwdata[2:0];
        end
    end

    always @* begin
        legacy_3a_next = legacy_3a_reg;
        if (wr_legacy) begin
            legacy_3a_next = hwdata[7:0];
        end
    end

    always @* begin
        allowed_next = svvd_allowed(card_detect_n, voltage_sense);
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata      <= hrdata_next;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vpp_request <= `SVVD_RESET_VPP;
        end else begin
            vpp_request <= vpp_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            video_passthrough_en <= 1'b0;
        end else begin
            video_passthrough_en <= video_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            socket_dma_channel_number <= `SVVD_RESET_DMA;
        end else begin
            socket_dma_channel_number <= dma_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            legacy_3a_reg <= `SVVD_RESET_LEGACY;
        end else begin
            legacy_3a_reg <= legacy_3a_next;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            allowed_voltages <= 4'h0;
        end else begin
            allowed_voltages <= allowed_next;
        end
    end
endmodule

// ===== verif/svvd_pwr.sv
`timescale 1ns/1ps
module svvd_pwr(
    input  wire [2:0] vpp_request,
    output wire [7:0] dv
);
    // Tenths of a volt; reserved codes are unsafe, so they apply nothing.
    assign dv = vpp_request == 3'h1 ? 8'h78 : vpp_request == 3'h2 ? 8'h32 :
                vpp_request == 3'h3 ? 8'h21 : 8'h00;
endmodule

// ===== verif/svvd_regs_monitor.sv
`timescale 1ns/1ps
module svvd_mon(
    input wire        hclk, hresetn, hsel, hwrite, hready, card_detect_n,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire [31:0] hrdata,
    input wire [2:0]  socket_dma_channel_number,
    input wire        video_passthrough_en,
    input wire [3:0]  allowed_voltages,
    input wire [31:0] hwdata,
    input wire [2:0]  vpp_request,
    input wire        hresp, hreadyout
);
    wire rd = hsel && hready && htrans[1] && !hwrite;
    wire wr = hsel && hready && htrans[1] && hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_video_read: assert property (rd && haddr == 8'h20 |=>
        hrdata == {31'h0, $past(video_passthrough_en)}) else $error("video");
    a_dma_read: assert property (rd && haddr == 8'h24 |=>
        hrdata == {29'h0, $past(socket_dma_channel_number)}) else $error("dma");
    a_card_gone: assert property (card_detect_n |=>
        allowed_voltages == 4'h0) else $error("allowed");
    a_vpp_write: assert property (wr && haddr == 8'h10 |=> ##1
        vpp_request == $past(hwdata[2:0])) else $error("vpp write");
    a_video_write: assert property (wr && haddr == 8'h20 |=> ##1
        video_passthrough_en == $past(hwdata[0])) else $error("video write");
    a_legacy_mirror: assert property (wr && haddr == 8'h28 |=> ##1
        video_passthrough_en == $past(hwdata[3])) else $error("mirror");
    a_dma_write: assert property (wr && haddr == 8'h24 |=> ##1
        socket_dma_channel_number == $past(hwdata[2:0])) else $error("dma wr");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response");
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, card_detect_n = 0;
    logic [7:0] haddr = 0, dv;
    logic [1:0] htrans = 0, voltage_sense = 0;
    logic [2:0] hsize = 3'h2, vpp_request, socket_dma_channel_number;
    logic [31:0] hwdata = 0, hrdata, q;
    logic hready, hreadyout, hresp, video_passthrough_en;
    logic [3:0] allowed_voltages;
    int err_total = 0, n_tests = 0;
    assign hready = hreadyout;
    svvd_regs uut(.*);
    svvd_pwr pwr(.vpp_request(vpp_request), .dv(dv));
    initial forever #2 hclk = ~hclk;
    task bus(input [7:0] a, input w, input [31:0] d);
        @(posedge hclk); hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task chk(input [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %0t %h %h", $time, g, e);
        end
    endtask
    task t_vpp;
        bit [7:0] mv [4] = '{8'h0, 8'h78, 8'h32, 8'h21};
        for (int i = 0; i < 4; i++) begin
            bus(8'h10, 1, 32'(i)); @(posedge hclk); chk(dv, mv[i]);
        end
        $display("vpp done");
    endtask
    task t_video;
        bus(8'h20, 0, 0); chk(q, 0);
        bus(8'h20, 1, '1); bus(8'h20, 0, 0); chk(q, 1);
        bus(8'h28, 0, 0); chk(q[3], 1);
        bus(8'h28, 1, 0); bus(8'h20, 0, 0); chk(q, 0);
        bus(8'h20, 1, 1); @(posedge hclk); hresetn <= 0;
        repeat (2) @(posedge hclk); hresetn <= 1;
        bus(8'h20, 0, 0); chk(q, 0);
        $display("video done");
    endtask
    task t_dma;
        for (int c = 0; c < 8; c++) begin
            bus(8'h24, 1, {29'h1fffffff, 3'(c)}); bus(8'h24, 0, 0);
            chk(q, 32'(c));
        end
        bus(8'h3c, 1, '1); bus(8'h3c, 0, 0); chk(q, 0);
        $display("dma done");
    endtask
    task t_card;
        bit [3:0] av [4] = '{4'h7, 4'h5, 4'h3, 4'h4};
        for (int s = 0; s < 4; s++) begin
            voltage_sense <= 2'(s); repeat (2) @(posedge hclk);
            chk(allowed_voltages, av[s]);
        end
        card_detect_n <= 1; repeat (2) @(posedge hclk);
        chk(allowed_voltages, 0); card_detect_n <= 0;
        $display("card done");
    endtask
    task print_verdict;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge hclk); hresetn <= 1;
        t_video; t_vpp; t_dma; t_card; print_verdict;
    end
    initial begin
        #20000; err_total++; print_verdict;
    end
endmodule
bind svvd_regs svvd_mon mon(.*);
